/* File: hw/scs_sequencer.sv */
// successive approximation conversion sequencer, 12-bit
//
// Contract
// RULE_01: busy high throughout a conversion
// RULE_02: 12-bit register drives result and feedback
// RULE_03: compare one bit per step, msb first
// RULE_04: keep or reject bit per comparator
// RULE_05: trigger sets the busy flag
// RULE_06: gated clock runs exactly 13 cycles
// RULE_07: trigger trailing edge initialises register, flags
// RULE_08: first step: bit 1 trial, rest set
// RULE_09: step n decides bit n, trials next
// RULE_10: busy drops 40 ns after last decision
// RULE_11: busy drop re-inhibits clock, held low
// RULE_12: bit valid on its decision edge
// RULE_13: host may latch on busy falling edge
// RULE_14: host trigger high 100ns, low meanwhile
// RULE_15: conversion starts on trigger falling edge
// RULE_16: lsb decided 40ns before busy falls
// RULE_17: outputs complemented straight or offset binary
// RULE_18: inverse msb output gives twos complement
// RULE_19: short cycle ends conversion early
// RULE_20: last result held until next trigger
// RULE_21: reset clears busy, asserts inhibit
`timescale 1ns/10ps
module scs_sequencer #(
   parameter int unsigned BIT_HALF = scs_pkg::BIT_HALF_DIV, // ref cycles per half gated clock
   parameter int unsigned SETTLE_CYC = scs_pkg::STATUS_DELAY_CYC // ref cycles from last decision to busy drop
) (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // host side pins
   input wire logic convert_i,
   input wire logic short_cycle_n_i,
   // analog side
   input wire logic comp_i,
   output logic [11:0] dac_code_o,
   // status and gated clock
   output logic busy_o,
   output logic gated_clk_o,
   // parallel result
   output scs_pkg::scs_result_s result_o
);
   // synchronised pins
   logic conv_lvl;
   logic comp_lvl;
   logic short_act; // short cycle requested; pin inverted first so reset means not requested
   logic conv_prev_ff;
   logic conv_fall;

   // state and counters
   scs_pkg::scs_state_e state_ff;
   scs_pkg::scs_state_e nxt_state;
   logic [11:0] apx_ff; // approximation_register, holds the complemented code
   logic [11:0] cur_mask; // bit decided at this gated rising edge
   logic [11:0] nxt_mask; // bit trialled next
   logic [3:0] step_ff; // gated clock cycle number, 0..12
   logic [7:0] div_ff; // half period divider
   logic half_tick; // one-cycle enable at each gated clock half
   logic clk_ff; // gated clock level
   logic [7:0] settle_ff;
   logic busy_ff;
   logic rise_en;
   logic last_step;

   // one-hot mask of bit number n, 1 = msb, 12 = lsb; zero outside, so the
   // trial after the lsb falls away without a special case
   function automatic logic [11:0] bit_mask(input logic [3:0] n);
      bit_mask = (n >= 4'h1 && n <= 4'(scs_pkg::RES_BITS)) ? (12'h800 >> (n - 4'h1)) : 12'h000;
   endfunction : bit_mask

   // pin synchronisers; comparator is asynchronous analog
   scs_sync u_sync_conv (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .pin_i(convert_i),
      .level_o(conv_lvl)
   );
   scs_sync u_sync_comp (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .pin_i(comp_i),
      .level_o(comp_lvl)
   );
   scs_sync u_sync_short (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .pin_i(~short_cycle_n_i),
      .level_o(short_act)
   );

   // trailing edge of the convert pulse; the rising edge does nothing
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         conv_prev_ff <= 1'b0;
      end else begin
         conv_prev_ff <= conv_lvl;
      end
   end
   assign conv_fall = conv_prev_ff & ~conv_lvl; // [RULE_15]

   // half period divider runs only while converting
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i || state_ff != scs_pkg::ST_CONV) begin
         div_ff <= 8'h00;
      end else if (half_tick) begin
         div_ff <= 8'h00;
      end else begin
         div_ff <= div_ff + 8'h01;
      end
   end
   assign half_tick = (state_ff == scs_pkg::ST_CONV) && (div_ff == 8'(BIT_HALF - 1));
   assign rise_en = half_tick & ~clk_ff;
   // short cycle low ends the sequence at the current decision
   // a short request only counts once bit 1 is decided, so t0 never ends the run
   assign last_step = (step_ff == 4'(scs_pkg::GCLK_CYCLES - 1)) || (short_act && step_ff != 4'h0); // [RULE_19]

   // next state
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         scs_pkg::ST_IDLE: begin
            if (conv_fall) begin
               nxt_state = scs_pkg::ST_CONV; // [RULE_05]
            end
         end
         scs_pkg::ST_CONV: begin
            // last decision made on this rising edge
            if (rise_en && last_step && step_ff != 4'h0) begin
               nxt_state = scs_pkg::ST_SETTLE;
            end
         end
         scs_pkg::ST_SETTLE: begin
            if (settle_ff == 8'(SETTLE_CYC - 1)) begin
               nxt_state = scs_pkg::ST_DONE; // [RULE_10]
            end
         end
         scs_pkg::ST_DONE: begin
            nxt_state = scs_pkg::ST_IDLE;
         end
         default: begin
            nxt_state = scs_pkg::ST_IDLE;
         end
      endcase
   end

   // state register; reset leaves busy low and clock inhibited
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         state_ff <= scs_pkg::ST_IDLE; // [RULE_21]
      end else begin
         state_ff <= nxt_state;
      end
   end

   // settle counter gives the delay before busy drops
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i || state_ff != scs_pkg::ST_SETTLE) begin
         settle_ff <= 8'h00;
      end else begin
         settle_ff <= settle_ff + 8'h01;
      end
   end

   // busy flag: set on the trailing edge, cleared after settle
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         busy_ff <= 1'b0; // [RULE_21]
      end else if (conv_fall && state_ff == scs_pkg::ST_IDLE) begin
         busy_ff <= 1'b1; // [RULE_05] [RULE_07]
      end else if (nxt_state == scs_pkg::ST_DONE) begin
         busy_ff <= 1'b0; // [RULE_10] [RULE_16]
      end
   end
   assign busy_o = busy_ff; // [RULE_01]

   // gated clock toggles only in conversion; inhibit forces low
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i || state_ff != scs_pkg::ST_CONV) begin
         clk_ff <= 1'b0; // [RULE_11] [RULE_07]
      end else if (half_tick) begin
         clk_ff <= ~clk_ff; // [RULE_06]
      end
   end
   assign gated_clk_o = clk_ff;

   // step counter counts rising gated edges, stops at 12, or earlier at the step where a short cycle ends the run
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i || (conv_fall && state_ff == scs_pkg::ST_IDLE)) begin
         step_ff <= 4'h0; // [RULE_07]
      end else if (rise_en && !last_step) begin
         step_ff <= step_ff + 4'h1; // [RULE_06]
      end
   end

   // approximation register; bits numbered 1 (msb) to 12 (lsb)
   // index 12-n holds bit n; decisions land on gated rising edges
   // masks for the decision at this step; msb first as steps count up
   assign cur_mask = bit_mask(step_ff); // [RULE_03]
   assign nxt_mask = bit_mask(step_ff + 4'h1); // [RULE_09]
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         apx_ff <= scs_pkg::APX_RST;
      end else if (conv_fall && state_ff == scs_pkg::ST_IDLE) begin
         apx_ff <= scs_pkg::APX_RST; // [RULE_07]
      end else if (rise_en) begin
         if (step_ff == 4'h0) begin
            // t0: bit 1 is the trial, others set
            apx_ff <= {1'b0, 11'h7FF}; // [RULE_08]
         end else begin
            // tn: comparator high means the trial exceeds the input, so bit n
            // returns to its set (rejected) level; bit n+1 becomes the trial
            apx_ff <= (apx_ff & ~cur_mask & ~nxt_mask) | ({12{comp_lvl}} & cur_mask); // [RULE_04] [RULE_09] [RULE_12]
         end
      end
   end

   // feedback follows the register directly, result one ref clock later; register
   // holds the last code until the next trailing edge
   assign dac_code_o = apx_ff; // [RULE_02]
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         // same code the register resets to, so the msb inverse stays consistent
         result_o.inverted_straight_binary <= scs_pkg::APX_RST; // [RULE_17]
         result_o.inverted_twos_complement_msb <= ~scs_pkg::APX_RST[11]; // [RULE_18]
      end else begin
         result_o.inverted_straight_binary <= apx_ff; // [RULE_02] [RULE_17] [RULE_20]
         result_o.inverted_twos_complement_msb <= ~apx_ff[11]; // [RULE_18]
      end
   end
endmodule : scs_sequencer

/* File: hw/scs_pkg.sv */
// shared constants and carrier types of the conversion sequencer
package scs_pkg;
   // result width and number of gated clock cycles per conversion
   localparam int unsigned RES_BITS = 12;
   localparam int unsigned GCLK_CYCLES = 13;
   // reference clock period and derived timing counts
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned STATUS_DELAY_NS = 40;
   localparam int unsigned STATUS_DELAY_CYC = (STATUS_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned TRIG_MIN_NS = 100;
   // default bit clock divider, ref cycles per half bit period
   localparam int unsigned BIT_HALF_DIV = 4;
   // reset value of the approximation register
   localparam logic [11:0] APX_RST = 12'h0FFF;

   // sequencer states, one-hot
   typedef enum logic [3:0] {
      ST_IDLE   = 4'b0001,
      ST_CONV   = 4'b0010,
      ST_SETTLE = 4'b0100,
      ST_DONE   = 4'b1000
   } scs_state_e;

   // parallel result carrier, all active low
   typedef struct packed {
      logic [11:0] inverted_straight_binary;
      logic inverted_twos_complement_msb;
   } scs_result_s;
endpackage : scs_pkg

/* File: hw/scs_sync.sv */
// three-stage synchroniser with agreement check for a pin input
`timescale 1ns/10ps
module scs_sync (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // pin side
   input wire logic pin_i,
   // synchronised level
   output logic level_o
);
   logic s1_ff; // first stage, read only by s2
   logic s2_ff; // second stage
   logic s3_ff; // third stage

   // shift chain
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         s1_ff <= 1'b0;
         s2_ff <= 1'b0;
         s3_ff <= 1'b0;
      end else begin
         s1_ff <= pin_i;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   // a change counts only once stages two and three agree
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         level_o <= 1'b0;
      end else if (s2_ff == s3_ff) begin
         level_o <= s3_ff;
      end
   end
endmodule : scs_sync

/* File: tb/scs_seq_assertions.sv */
// port checker for the conversion sequencer
`timescale 1ns/10ps
module scs_seq_checker #(
   parameter int unsigned BIT_HALF = 4,
   parameter int unsigned SETTLE_CYC = 4
) (
   // clock, reset and pins
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic convert_i,
   input wire logic short_cycle_n_i,
   input wire logic comp_i,
   // outputs watched
   input wire logic [11:0] dac_code_o,
   input wire logic busy_o,
   input wire logic gated_clk_o,
   input wire scs_pkg::scs_result_s result_o
);
   localparam int LO = 24 * BIT_HALF + SETTLE_CYC; // shortest busy run
   localparam int HI = 28 * BIT_HALF + SETTLE_CYC + 4; // longest busy run
   localparam int SLO = 2 * BIT_HALF + SETTLE_CYC; // shortest busy run, short cycle after bit 1
   localparam int SHI = 6 * BIT_HALF + SETTLE_CYC + 4; // longest busy run, short cycle after bit 1
   logic g_ff; // last gated clock level
   logic [7:0] gcnt_ff, bcnt_ff, scnt_ff; // edges, busy length, age of last edge
   wire g_rise = gated_clk_o & ~g_ff;
   // edge and busy counters restart per conversion so each busy fall judges one run only
   always_ff @(posedge ref_clk_i) begin
      g_ff <= gated_clk_o;
      gcnt_ff <= (!rst_n_i || $fell(convert_i)) ? 8'h00 : gcnt_ff + {7'h00, g_rise};
      bcnt_ff <= busy_o ? bcnt_ff + 8'h01 : 8'h00;
      scnt_ff <= g_rise ? 8'h00 : scnt_ff + {7'h00, scnt_ff != 8'hff};
   end
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   property p_start; $fell(convert_i) && !busy_o |-> ##[2:8] busy_o; endproperty
   a_start: assert property (p_start) else $error("busy missed trailing edge");
   property p_lead; $rose(convert_i) && !busy_o |=> !busy_o [*8]; endproperty
   a_lead: assert property (p_lead) else $error("busy rose on leading edge");
   property p_trial; $rose(busy_o) |-> ##[0:12] (dac_code_o == 12'h7ff); endproperty
   a_trial: assert property (p_trial) else $error("no first trial pattern");
   property p_edges; $fell(busy_o) |-> gcnt_ff == (short_cycle_n_i ? 8'h0d : 8'h02); endproperty
   a_edges: assert property (p_edges) else $error("gated clock edge count");
   property p_len;
      $fell(busy_o) |-> (short_cycle_n_i ? (bcnt_ff >= LO && bcnt_ff <= HI) : (bcnt_ff >= SLO && bcnt_ff <= SHI));
   endproperty
   a_len: assert property (p_len) else $error("busy length");
   property p_settle; $fell(busy_o) |-> scnt_ff + 1 >= SETTLE_CYC && scnt_ff <= SETTLE_CYC + 3; endproperty
   a_settle: assert property (p_settle) else $error("last decision to busy fall");
   property p_idle; !busy_o && !$past(busy_o) |-> !gated_clk_o; endproperty
   a_idle: assert property (p_idle) else $error("gated clock while idle");
   property p_follow; busy_o && $past(busy_o) |-> result_o.inverted_straight_binary == $past(dac_code_o); endproperty
   a_follow: assert property (p_follow) else $error("result lags register");
   property p_inv; result_o.inverted_twos_complement_msb == !result_o.inverted_straight_binary[11]; endproperty
   a_inv: assert property (p_inv) else $error("msb inverse wrong");
   property p_hold; !busy_o && !$past(busy_o) && convert_i |-> $stable(result_o); endproperty
   a_hold: assert property (p_hold) else $error("result moved while idle");
endmodule : scs_seq_checker

bind scs_sequencer scs_seq_checker #(.BIT_HALF(BIT_HALF), .SETTLE_CYC(SETTLE_CYC)) u_chk (.ref_clk_i(ref_clk_i),
   .rst_n_i(rst_n_i), .convert_i(convert_i), .short_cycle_n_i(short_cycle_n_i), .comp_i(comp_i),
   .dac_code_o(dac_code_o), .busy_o(busy_o), .gated_clk_o(gated_clk_o), .result_o(result_o));

/* File: tb/scs_host_model.sv */
// host and comparator model facing the sequencer
`timescale 1ns/10ps
module scs_host_model (
   // clock and request from the bench
   input wire logic ref_clk_i,
   input wire logic start_i,
   input wire logic [11:0] level_i,
   // sequencer side
   input wire logic [11:0] dac_code_i,
   input wire logic busy_i,
   input wire scs_pkg::scs_result_s result_i,
   output logic convert_o = 1'b0,
   output logic comp_o,
   // captured result
   output logic got_o = 1'b0,
   output scs_pkg::scs_result_s data_o
);
   logic [3:0] hcnt = 4'h0; // remaining high cycles of the trigger
   logic busy_q = 1'b0; // busy one edge ago
   // register holds the complement, so the trial value is its inverse; 1 rejects
   assign comp_o = (~dac_code_i) > level_i;
   // trigger pulse and capture on the busy fall
   always @(posedge ref_clk_i) begin
      busy_q <= busy_i;
      got_o <= busy_q & ~busy_i;
      if (busy_q & ~busy_i) begin
         data_o <= result_i;
      end
      if (start_i) begin
         convert_o <= 1'b1; // 12 cycles high, well over the minimum
         hcnt <= 4'hb;
      end else if (hcnt != 4'h0) begin
         hcnt <= hcnt - 4'h1;
      end else begin
         convert_o <= 1'b0; // stays low until the next start
      end
   end
endmodule : scs_host_model

/* File: tb/tb_top.sv */
// self-checking bench for the conversion sequencer
`timescale 1ns/10ps
module tb_top;
   logic ref_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic start = 1'b0; // one-cycle request to the host model
   logic short_n = 1'b1; // short cycle pin; low ends the run after bit 1
   logic [11:0] level = 12'h000; // analog level as a code
   logic [11:0] dac;
   logic convert, comp, busy, gclk, got;
   scs_pkg::scs_result_s res, data;
   scs_pkg::scs_result_s exp_q[$]; // expected captures, oldest first
   int err_count = 0;
   int tests_run = 0;
   logic [31:0] seed = 32'h0000_e1c5;
   logic [11:0] dir_v[5] = '{12'h000, 12'hfff, 12'h800, 12'h7ff, 12'h001}; // range ends and msb edges
   always #5 ref_clk_i = ~ref_clk_i;
   scs_sequencer dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .convert_i(convert), .short_cycle_n_i(short_n),
      .comp_i(comp), .dac_code_o(dac), .busy_o(busy), .gated_clk_o(gclk), .result_o(res));
   scs_host_model host (.ref_clk_i(ref_clk_i), .start_i(start), .level_i(level), .dac_code_i(dac),
      .busy_i(busy), .result_i(res), .convert_o(convert), .comp_o(comp), .got_o(got), .data_o(data));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs
   task automatic finish_test;
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : finish_test
   task automatic cmp_res(input scs_pkg::scs_result_s g, input scs_pkg::scs_result_s e);
      tests_run++;
      if (g !== e) begin
         err_count++;
         $display("mismatch at %0t got %h exp %h", $time, g, e);
      end
   endtask : cmp_res
   task automatic cmp_flag(input logic g, input logic e);
      tests_run++;
      if (g !== e) begin
         err_count++;
         $display("mismatch at %0t got %h exp %h", $time, g, e);
      end
   endtask : cmp_flag
   // one conversion; a reset after rst_at cycles aborts it, 0 runs it whole
   task automatic run_conv(input logic [11:0] v, input int rst_at);
      int k;
      level <= v;
      // a short run keeps bit 1, leaves bit 2 at its trial level and bits 3..12 set
      exp_q.push_back(rst_at != 0 ? {12'hfff, 1'b0} : !short_n ? {~v[11], 1'b0, 10'h3ff, v[11]} : {~v, v[11]});
      start <= 1'b1;
      @(posedge ref_clk_i) start <= 1'b0;
      if (rst_at != 0) begin
         repeat (rst_at) @(posedge ref_clk_i);
         rst_n_i <= 1'b0;
         repeat (4) @(posedge ref_clk_i);
         rst_n_i <= 1'b1;
         cmp_flag(busy, 1'b0);
         cmp_flag(gclk, 1'b0);
      end else begin
         for (k = 0; k < 400 && got !== 1'b1; k++) @(posedge ref_clk_i);
         if (k == 400) begin
            err_count++;
            finish_test();
         end
      end
      repeat (4) @(posedge ref_clk_i);
   endtask : run_conv
   // capture watcher: each host capture is judged against the oldest note
   always @(posedge ref_clk_i) begin
      if (got === 1'b1) begin
         cmp_res(data, exp_q.size() != 0 ? exp_q.pop_front() : 'x);
      end
   end
   initial begin
      repeat (4) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      // values read here are those settled after the first edge out of reset
      repeat (2) @(posedge ref_clk_i);
      cmp_flag(busy, 1'b0);
      cmp_flag(gclk, 1'b0);
      cmp_res(res, {12'hfff, 1'b0});
      $display("test reset done");
      foreach (dir_v[i]) run_conv(dir_v[i], 0);
      $display("test directed done");
      repeat (12) begin
         seed = xs(seed);
         run_conv(seed[11:0], 0);
      end
      $display("test random done");
      run_conv(12'h5a5, 50);
      run_conv(12'h3c3, 0);
      $display("test reset_mid done");
      // short cycle held low across whole runs; one edge lets the pin settle first
      short_n <= 1'b0;
      @(posedge ref_clk_i);
      run_conv(12'h9a6, 0);
      run_conv(12'h35c, 0);
      short_n <= 1'b1;
      $display("test short_cycle done");
      finish_test();
   end
endmodule : tb_top
